/* File: pcu_pkg.sv */
package pcu_pkg;
   // Geometry
   localparam int NUM_CH = 4;
   localparam int CNT_W = 32;
   localparam int EVT_W = 6;
   localparam int NUM_EVT = 38;

   // Register byte offsets
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_STATUS = 8'h04;
   localparam logic [7:0] OFF_SEL0 = 8'h10;
   localparam logic [7:0] OFF_CNT0 = 8'h20;

   // Field positions
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_INIT_BIT = 4;
   localparam int CTRL_ARM_BIT = 5;
   localparam int STAT_WIN_BIT = 0;
   localparam int STAT_OVF_LSB = 4;
   localparam int STAT_CFGERR_BIT = 8;

   // Reset values
   localparam logic [1:0] MODE_RST = 2'h0;
   localparam logic [5:0] SEL_RST = 6'h00;
   localparam logic [31:0] CNT_RST = 32'h0000_0000;

   // Branch weight
   localparam logic [31:0] BRANCH_STEP = 32'h0000_0002;

   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      PCU_WIN_NORMAL = 2'h0,
      PCU_WIN_1TO2 = 2'h1,
      PCU_WIN_2TO1 = 2'h2
   } pcu_mode_t;

   // Event selector codes; bit index of event vector equals code
   typedef enum logic [5:0] {
      EV_DISABLED = 6'h00, EV_ELAPSED_TIME = 6'h01, EV_EXECUTION_STATES = 6'h02,
      EV_BRANCH_INSTR_COUNT = 6'h03, EV_EXEC_INSTRS = 6'h04, EV_DSP_INSTR_COUNT = 6'h05,
      EV_FETCH_LOAD_CONFLICT = 6'h06, EV_OTHER_CONFLICT = 6'h07, EV_EXCEPTION_IRQ = 6'h08,
      EV_DATA_TLB_MISS = 6'h09, EV_INSTR_TLB_MISS = 6'h0a, EV_IRQ_COUNT = 6'h0b,
      EV_BLOCK_BIT_SET = 6'h0c, EV_PRIVILEGED_MODE = 6'h0d, EV_INSTR_CACHE_MISS = 6'h0e,
      EV_DATA_CACHE_MISS = 6'h0f, EV_FETCH_STALL = 6'h10, EV_LOAD_STORE_STALL = 6'h11,
      EV_ICACHE_MISS_STALL = 6'h12, EV_DCACHE_MISS_STALL = 6'h13, EV_UNCACHED_STALL = 6'h14,
      EV_XY_RAM_STALL = 6'h15, EV_LOCAL_RAM_STALL = 6'h16, EV_FETCH_LOAD_STALL = 6'h17,
      EV_OTHER_ACC_CYC = 6'h18, EV_UNC_AREA_CYC = 6'h19, EV_UNC_FETCH_CYC = 6'h1a,
      EV_UNC_DATA_CYC = 6'h1b, EV_CACHED_AREA_CYC = 6'h1c, EV_CACHED_FETCH_CYC = 6'h1d,
      EV_CACHED_DATA_CYC = 6'h1e, EV_OTHER_ACC_CNT = 6'h1f, EV_UNC_AREA_CNT = 6'h20,
      EV_UNC_FETCH_CNT = 6'h21, EV_UNC_DATA_CNT = 6'h22, EV_CACHED_AREA_CNT = 6'h23,
      EV_CACHED_FETCH_CNT = 6'h24, EV_CACHED_DATA_CNT = 6'h25
   } pcu_evt_t;
endpackage : pcu_pkg

/* File: pcu_channel.sv */
// One counting channel: event mux, 32-bit counter, sticky overflow
module pcu_channel #(
   parameter int CNT_W = pcu_pkg::CNT_W,
   parameter int NUM_EVT = pcu_pkg::NUM_EVT
) (
   input wire logic clk_in,
   input wire logic srst_in,
   input wire logic init_in,
   input wire logic count_en_in,
   input wire logic [pcu_pkg::EVT_W-1:0] sel_in,
   input wire logic [NUM_EVT-1:0] events_in,
   output logic [CNT_W-1:0] count_out,
   output logic ovf_out
);
   import pcu_pkg::*;

   logic [CNT_W-1:0] count_reg;
   logic [CNT_W-1:0] count_next;
   logic ovf_reg;
   logic ovf_next;
   logic [CNT_W-1:0] step;
   logic [CNT_W:0] sum;
   logic hit;
   logic is_branch;
   logic is_off;

   // Event select and weighting
   assign is_off = (sel_in == EV_DISABLED);
   assign is_branch = (sel_in == EV_BRANCH_INSTR_COUNT);
   assign hit = !is_off && (32'(sel_in) < NUM_EVT) && events_in[sel_in] && count_en_in;
   assign step = is_branch ? CNT_W'(BRANCH_STEP) : CNT_W'(1);
   assign sum = {1'b0, count_reg} + {1'b0, step};
   assign count_next = init_in ? CNT_W'(CNT_RST) : (hit ? sum[CNT_W-1:0] : count_reg);
   // Overflow sticky until init; a wrap in the init cycle still sets it
   assign ovf_next = (hit && sum[CNT_W]) || (!init_in && ovf_reg);

   // Counter runs on the core clock only, so it pauses when that clock is gated
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         count_reg <= CNT_W'(CNT_RST);
         ovf_reg <= 1'b0;
      end else begin
         count_reg <= count_next;
         ovf_reg <= ovf_next;
      end
   end

   // Disabled channel reads zero
   assign count_out = is_off ? '0 : count_reg;
   assign ovf_out = ovf_reg;
endmodule : pcu_channel

/* File: pcu_top.sv */
// Behaviour
// - Four independent channels count concurrently.
// - Normal window: run start to break.
// - Window opens on match one, closes on two.
// - Window opens on match two, closes on one.
// - Window matches never halt program execution.
// - Selector covers core execution and miss events.
// - Counts block-bit and privileged-mode instructions.
// - Two distinct conflict-cycle events.
// - Eight stall-cycle event classes.
// - Access cycles split by area and kind.
// - Access counts split by area and kind.
// - TLB-uncached cacheable accesses count as cacheable.
// - Cache-on area counts may be skewed.
// - Branch event adds two per branch.
// - Counters clocked by core clock.
// - Trace mode counts may be inaccurate.
// - Each result is a 32-bit readable counter.
// - Overflow detected and reported per channel.
// - Window edges may be slightly offset.
// - Host init clears all results; a wrap in the init cycle still sets that channel's overflow.
//
// Chosen here: the AXI4-Lite slave port and the address map.
module pcu_top #(
   parameter int NUM_CH = pcu_pkg::NUM_CH,
   parameter int CNT_W = pcu_pkg::CNT_W
) (
   input wire logic clk_in,
   input wire logic srst_in,
   // Core status inputs and window break mask output
   input wire logic prog_run_in,
   input wire logic break_in,
   input wire logic match1_in,
   input wire logic match2_in,
   input wire logic [pcu_pkg::NUM_EVT-1:0] events_in,
   output logic window_break_mask_out,
   // AXI4-Lite slave
   input wire logic [7:0] s_axi_awaddr_in,
   input wire logic s_axi_awvalid_in,
   output logic s_axi_awready_out,
   input wire logic [31:0] s_axi_wdata_in,
   input wire logic [3:0] s_axi_wstrb_in,
   input wire logic s_axi_wvalid_in,
   output logic s_axi_wready_out,
   output logic [1:0] s_axi_bresp_out,
   output logic s_axi_bvalid_out,
   input wire logic s_axi_bready_in,
   input wire logic [7:0] s_axi_araddr_in,
   input wire logic s_axi_arvalid_in,
   output logic s_axi_arready_out,
   output logic [31:0] s_axi_rdata_out,
   output logic [1:0] s_axi_rresp_out,
   output logic s_axi_rvalid_out,
   input wire logic s_axi_rready_in
);
   import pcu_pkg::*;

   typedef enum logic [1:0] {
      PCU_IDLE = 2'b00,
      PCU_WAIT = 2'b01,
      PCU_COUNT = 2'b11,
      PCU_DONE = 2'b10
   } pcu_state_t;

   pcu_state_t state_reg;
   pcu_state_t state_next;
   logic [1:0] mode_reg;
   logic [EVT_W-1:0] sel_reg [NUM_CH];
   logic cfg_err_reg;
   logic init_pulse;
   logic arm_pulse;
   logic count_en;
   logic start_hit;
   logic stop_hit;
   logic win_mode;
   logic any_enabled;
   logic [CNT_W-1:0] cnt_val [NUM_CH];
   logic [NUM_CH-1:0] ovf;
   logic [NUM_CH-1:0] ch_on;

   // Write channel capture: address and data accepted in either order
   logic aw_held_reg;
   logic w_held_reg;
   logic [7:0] aw_addr_reg;
   logic [31:0] w_data_reg;
   logic [3:0] w_strb_reg;
   logic bvalid_reg;
   logic [1:0] bresp_reg;
   logic wr_fire;
   logic wr_hit;
   logic [7:0] wa;

   assign s_axi_awready_out = !aw_held_reg && !bvalid_reg;
   assign s_axi_wready_out = !w_held_reg && !bvalid_reg;
   assign wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;
   assign wa = aw_addr_reg;
   assign wr_hit = (wa == OFF_CTRL) ||
      ((wa >= OFF_SEL0) && (wa < OFF_SEL0 + 8'(4 * NUM_CH)) && (wa[1:0] == 2'b00));

   // Write handshake state
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
         aw_addr_reg <= 8'h00;
         w_data_reg <= 32'h0000_0000;
         w_strb_reg <= 4'h0;
         bvalid_reg <= 1'b0;
         bresp_reg <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid_in && s_axi_awready_out) begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr_in;
         end
         if (s_axi_wvalid_in && s_axi_wready_out) begin
            w_held_reg <= 1'b1;
            w_data_reg <= s_axi_wdata_in;
            w_strb_reg <= s_axi_wstrb_in;
         end
         if (wr_fire) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            bvalid_reg <= 1'b1;
            bresp_reg <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (bvalid_reg && s_axi_bready_in) begin
            bvalid_reg <= 1'b0;
         end
      end
   end

   assign s_axi_bvalid_out = bvalid_reg;
   assign s_axi_bresp_out = bresp_reg;

   // Control writes: low byte carries mode, init and arm
   logic ctrl_wr;
   assign ctrl_wr = wr_fire && (wa == OFF_CTRL) && w_strb_reg[0];
   assign init_pulse = ctrl_wr && w_data_reg[CTRL_INIT_BIT];
   assign arm_pulse = ctrl_wr && w_data_reg[CTRL_ARM_BIT];

   // Mode register; only changeable while no window is live
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         mode_reg <= MODE_RST;
      end else if (ctrl_wr && state_reg != PCU_COUNT) begin
         mode_reg <= w_data_reg[CTRL_MODE_LSB +: 2];
      end
   end

   // Per-channel selectors, all channels independent
   genvar g;
   generate
      for (g = 0; g < NUM_CH; g++) begin : g_ch
         logic sel_wr;
         assign sel_wr = wr_fire && (wa == OFF_SEL0 + 8'(4 * g)) && w_strb_reg[0];
         always_ff @(posedge clk_in) begin
            if (srst_in) begin
               sel_reg[g] <= SEL_RST;
            end else if (sel_wr) begin
               sel_reg[g] <= w_data_reg[EVT_W-1:0];
            end
         end
         assign ch_on[g] = (sel_reg[g] != EV_DISABLED);
         // Area split comes from core event inputs as-is; TLB-uncached
         // cacheable accesses arrive on the cacheable lines, and cache-on
         // skew is inherent to those inputs
         pcu_channel #(
            .CNT_W(CNT_W),
            .NUM_EVT(NUM_EVT)
         ) u_ch (
            .clk_in(clk_in),
            .srst_in(srst_in),
            .init_in(init_pulse),
            .count_en_in(count_en),
            .sel_in(sel_reg[g]),
            .events_in(events_in),
            .count_out(cnt_val[g]),
            .ovf_out(ovf[g])
         );
      end
   endgenerate

   // Window control
   assign win_mode = (mode_reg == PCU_WIN_1TO2) || (mode_reg == PCU_WIN_2TO1);
   assign any_enabled = |ch_on;
   assign start_hit = (mode_reg == PCU_WIN_1TO2) ? match1_in :
                      (mode_reg == PCU_WIN_2TO1) ? match2_in : prog_run_in;
   assign stop_hit = (mode_reg == PCU_WIN_1TO2) ? match2_in :
                     (mode_reg == PCU_WIN_2TO1) ? match1_in : break_in;
   // Matches in window modes are routed here only; core must not halt on them
   assign window_break_mask_out = win_mode;

   // Window sequencer; arm with no enabled channel in window mode is refused
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         PCU_IDLE: begin
            if (arm_pulse && !(win_mode && !any_enabled)) begin
               state_next = PCU_WAIT;
            end
         end
         PCU_WAIT: begin
            if (start_hit) begin
               state_next = PCU_COUNT;
            end
         end
         PCU_COUNT: begin
            // Stop gates counting in its own cycle while start counts from the next, so edges may be off by one
            if (stop_hit) begin
               state_next = PCU_DONE;
            end
         end
         PCU_DONE: begin
            if (arm_pulse && !(win_mode && !any_enabled)) begin
               state_next = PCU_WAIT;
            end
         end
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         state_reg <= PCU_IDLE;
         cfg_err_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         if (arm_pulse) begin
            cfg_err_reg <= win_mode && !any_enabled;
         end
      end
   end

   // Count only inside window; outside it counters hold
   assign count_en = (state_reg == PCU_COUNT) && !stop_hit;

   // Read channel
   logic rvalid_reg;
   logic [31:0] rdata_reg;
   logic [1:0] rresp_reg;
   logic [7:0] ra;
   logic [31:0] rd_mux;
   logic rd_ok;
   logic [31:0] status_word;
   logic [31:0] ctrl_word;
   logic [31:0] sel_word;
   logic [31:0] cnt_word;
   logic [7:0] rel_sel;
   logic [7:0] rel_cnt;
   logic rd_is_ctrl;
   logic rd_is_status;
   logic rd_is_sel;
   logic rd_is_cnt;

   // Read address offsets within the selector and counter banks
   assign s_axi_arready_out = !rvalid_reg;
   assign ra = s_axi_araddr_in;
   assign rel_sel = ra - OFF_SEL0;
   assign rel_cnt = ra - OFF_CNT0;

   // Status fields placed by the shared field positions, except the state code at bits 2:1
   always_comb begin
      status_word = 32'h0000_0000;
      status_word[STAT_WIN_BIT] = (state_reg == PCU_COUNT);
      status_word[2:1] = 2'(state_reg);
      status_word[STAT_OVF_LSB +: 4] = 4'(ovf);
      status_word[STAT_CFGERR_BIT] = cfg_err_reg;
   end

   // Word sources; counter width may differ from the bus width
   assign ctrl_word = {30'h0, mode_reg};
   assign sel_word = {26'h0, sel_reg[rel_sel[3:2]]};
   assign cnt_word = 32'(cnt_val[rel_cnt[3:2]]);

   // Address decode; every register is one aligned word
   assign rd_is_ctrl = (ra == OFF_CTRL);
   assign rd_is_status = (ra == OFF_STATUS);
   assign rd_is_sel = (ra >= OFF_SEL0) && (ra < OFF_SEL0 + 8'(4 * NUM_CH)) && (ra[1:0] == 2'b00);
   assign rd_is_cnt = (ra >= OFF_CNT0) && (ra < OFF_CNT0 + 8'(4 * NUM_CH)) && (ra[1:0] == 2'b00);
   assign rd_ok = rd_is_ctrl || rd_is_status || rd_is_sel || rd_is_cnt;

   // Selection by decoded hit, so gaps between banks never alias
   assign rd_mux = rd_is_ctrl ? ctrl_word :
                   rd_is_status ? status_word :
                   rd_is_cnt ? cnt_word :
                   rd_is_sel ? sel_word : 32'h0000_0000;

   // Read data registered; unmapped addresses answer SLVERR with zero
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         rresp_reg <= RESP_OKAY;
      end else if (s_axi_arvalid_in && s_axi_arready_out) begin
         rvalid_reg <= 1'b1;
         rdata_reg <= rd_ok ? rd_mux : 32'h0000_0000;
         rresp_reg <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_reg && s_axi_rready_in) begin
         rvalid_reg <= 1'b0;
      end
   end

   assign s_axi_rvalid_out = rvalid_reg;
   assign s_axi_rdata_out = rdata_reg;
   assign s_axi_rresp_out = rresp_reg;
endmodule : pcu_top

/* File: pcu_chk.sv */
module pcu_chk #(
   parameter int NUM_CH = 4,
   parameter int CNT_W = 32
) (
   input wire logic clk_in,
   input wire logic srst_in,
   input wire logic prog_run_in,
   input wire logic break_in,
   input wire logic match1_in,
   input wire logic match2_in,
   input wire logic [pcu_pkg::NUM_EVT-1:0] events_in,
   input wire logic window_break_mask_out,
   input wire logic [7:0] s_axi_awaddr_in,
   input wire logic s_axi_awvalid_in,
   input wire logic s_axi_awready_out,
   input wire logic [31:0] s_axi_wdata_in,
   input wire logic [3:0] s_axi_wstrb_in,
   input wire logic s_axi_wvalid_in,
   input wire logic s_axi_wready_out,
   input wire logic [1:0] s_axi_bresp_out,
   input wire logic s_axi_bvalid_out,
   input wire logic s_axi_bready_in,
   input wire logic [7:0] s_axi_araddr_in,
   input wire logic s_axi_arvalid_in,
   input wire logic s_axi_arready_out,
   input wire logic [31:0] s_axi_rdata_out,
   input wire logic [1:0] s_axi_rresp_out,
   input wire logic s_axi_rvalid_out,
   input wire logic s_axi_rready_in
);
   import pcu_pkg::*;
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (srst_in);

   // Answers stand until the host takes them
   chk_bvalid_hold: assert property (s_axi_bvalid_out && !s_axi_bready_in
      |=> s_axi_bvalid_out && $stable(s_axi_bresp_out)) else $error("write answer dropped");
   chk_rvalid_hold: assert property (s_axi_rvalid_out && !s_axi_rready_in
      |=> s_axi_rvalid_out && $stable(s_axi_rdata_out)) else $error("read answer dropped");
   // Read answers one cycle after its address, write two after both halves
   chk_read_answer: assert property (s_axi_arvalid_in && s_axi_arready_out
      |=> s_axi_rvalid_out) else $error("read answer late");
   chk_write_answer: assert property (s_axi_awvalid_in && s_axi_awready_out
      && s_axi_wvalid_in && s_axi_wready_out |-> ##2 s_axi_bvalid_out)
      else $error("write answer late");
   // One outstanding read transfer at a time
   chk_read_refuse: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
      else $error("read accepted while answer pending");
   // Unmapped reads and read-only writes are refused
   chk_unmapped_read: assert property (s_axi_arvalid_in && s_axi_arready_out
      && s_axi_araddr_in == 8'hfc |=> s_axi_rresp_out == RESP_SLVERR && s_axi_rdata_out == '0)
      else $error("unmapped read not refused");
   chk_ro_write: assert property (s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in
      && s_axi_wready_out && s_axi_awaddr_in == OFF_STATUS |-> ##2 s_axi_bresp_out == RESP_SLVERR)
      else $error("status write not refused");
   // Quiet bus and normal mode straight after reset
   chk_reset_idle: assert property ($fell(srst_in) |-> !s_axi_bvalid_out && !s_axi_rvalid_out
      && s_axi_awready_out && s_axi_arready_out && !window_break_mask_out)
      else $error("not idle after reset");
endmodule : pcu_chk

/* File: pcu_host.sv */
// Debug host side of the register bus
module pcu_host (
   input wire logic clk_in,
   output logic [7:0] awaddr_out,
   output logic awvalid_out,
   output logic [31:0] wdata_out,
   output logic [3:0] wstrb_out,
   output logic wvalid_out,
   output logic bready_out,
   output logic [7:0] araddr_out,
   output logic arvalid_out,
   output logic rready_out,
   input wire logic awready_in,
   input wire logic wready_in,
   input wire logic [1:0] bresp_in,
   input wire logic bvalid_in,
   input wire logic arready_in,
   input wire logic [31:0] rdata_in,
   input wire logic [1:0] rresp_in,
   input wire logic rvalid_in
);
   timeunit 1ns;
   timeprecision 1ps;

   // Quiet bus at time zero
   initial begin
      {awaddr_out, awvalid_out, wdata_out, wstrb_out, wvalid_out} = '0;
      {bready_out, araddr_out, arvalid_out, rready_out} = '0;
   end

   // Released payload is inverted so stale values cannot pass
   task automatic write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      awaddr_out <= a;
      wdata_out <= d;
      wstrb_out <= 4'hf;
      {awvalid_out, wvalid_out, bready_out} <= 3'h7;
      do begin
         @(posedge clk_in);
         if (awvalid_out && awready_in) begin
            awvalid_out <= 1'b0;
            awaddr_out <= ~a;
         end
         if (wvalid_out && wready_in) begin
            wvalid_out <= 1'b0;
            wdata_out <= ~d;
         end
      end while (!bvalid_in);
      r = bresp_in;
      bready_out <= 1'b0;
      @(posedge clk_in);
   endtask : write

   task automatic read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      araddr_out <= a;
      {arvalid_out, rready_out} <= 2'h3;
      do begin
         @(posedge clk_in);
         if (arvalid_out && arready_in) begin
            arvalid_out <= 1'b0;
            araddr_out <= ~a;
         end
      end while (!rvalid_in);
      d = rdata_in;
      r = rresp_in;
      rready_out <= 1'b0;
      @(posedge clk_in);
   endtask : read
endmodule : pcu_host

/* File: cpu_performance_counter_unit_tb.sv */
module cpu_performance_counter_unit_tb;
   import pcu_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_in, srst_in, prog_run_in, break_in, match1_in, match2_in, window_break_mask_out;
   logic [NUM_EVT-1:0] events_in;
   logic [7:0] s_axi_awaddr_in, s_axi_araddr_in;
   logic [31:0] s_axi_wdata_in, s_axi_rdata_out;
   logic [3:0] s_axi_wstrb_in;
   logic [1:0] s_axi_bresp_out, s_axi_rresp_out;
   logic s_axi_awvalid_in, s_axi_awready_out, s_axi_wvalid_in, s_axi_wready_out;
   logic s_axi_bvalid_out, s_axi_bready_in, s_axi_arvalid_in, s_axi_arready_out;
   logic s_axi_rvalid_out, s_axi_rready_in;
   int n_fail = 0;
   int compares = 0;
   int cycles = 0;

   pcu_top dut_u (.*);
   pcu_host host_u (.clk_in(clk_in), .awaddr_out(s_axi_awaddr_in),
      .awvalid_out(s_axi_awvalid_in), .wdata_out(s_axi_wdata_in), .wstrb_out(s_axi_wstrb_in),
      .wvalid_out(s_axi_wvalid_in), .bready_out(s_axi_bready_in), .araddr_out(s_axi_araddr_in),
      .arvalid_out(s_axi_arvalid_in), .rready_out(s_axi_rready_in),
      .awready_in(s_axi_awready_out), .wready_in(s_axi_wready_out), .bresp_in(s_axi_bresp_out),
      .bvalid_in(s_axi_bvalid_out), .arready_in(s_axi_arready_out), .rdata_in(s_axi_rdata_out),
      .rresp_in(s_axi_rresp_out), .rvalid_in(s_axi_rvalid_out));

   initial begin
      clk_in = 1'b0;
      forever #4 clk_in = ~clk_in;
   end

   // Hang guard, far above the well under a thousand cycles the run needs
   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 20000) begin
         n_fail++;
         $display("BAD %0t run timed out", $time);
         results();
      end
   end

   task automatic results();
      $display("Compares %0d mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : results

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic [1:0] r;
      host_u.write(a, d, r);
      check({30'h0, r}, {30'h0, er});
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      logic [1:0] r;
      host_u.read(a, d, r);
      check({30'h0, r}, {30'h0, RESP_OKAY});
   endtask : rd

   // One-cycle strobe: 0 run, 1 break, 2 match one, 3 match two
   task automatic pulse(input int k);
      {prog_run_in, break_in, match1_in, match2_in} <= 4'h8 >> k;
      @(posedge clk_in);
      {prog_run_in, break_in, match1_in, match2_in} <= 4'h0;
      @(posedge clk_in);
   endtask : pulse

   // All event strobes high for n cycles
   task automatic ev(input int n);
      events_in <= '1;
      repeat (n) @(posedge clk_in);
      events_in <= '0;
      @(posedge clk_in);
   endtask : ev

   // Events outside the window must not count; only the 9 inside do
   task automatic run_window(input int m, input int base);
      logic [5:0] sel [4];
      logic [31:0] d;
      for (int c = 0; c < 4; c++) begin
         sel[c] = (base + c < NUM_EVT) ? 6'(base + c) : SEL_RST;
         wr(OFF_SEL0 + 8'(4 * c), {26'h0, sel[c]}, RESP_OKAY);
      end
      wr(OFF_CTRL, 32'h10 | 32'(m), RESP_OKAY);
      wr(OFF_CTRL, 32'h20 | 32'(m), RESP_OKAY);
      ev(3);
      if (m != 0) begin
         // Window modes run free from the start strobe, never single-stepped
         pulse(0);
         ev(3);
      end
      pulse(m == 0 ? 0 : m + 1);
      rd(OFF_STATUS, d);
      check({31'h0, d[STAT_WIN_BIT]}, 32'h1);
      check({31'h0, window_break_mask_out}, 32'(m != 0));
      ev(9);
      pulse(m == 0 ? 1 : 4 - m);
      ev(3);
      for (int c = 0; c < 4; c++) begin
         rd(OFF_CNT0 + 8'(4 * c), d);
         check(d, sel[c] == SEL_RST ? 0 : sel[c] == EV_BRANCH_INSTR_COUNT ? 18 : 9);
      end
   endtask : run_window

   // Refusals, clearing, and a window mode with nothing enabled
   task automatic misc();
      logic [31:0] d;
      logic [1:0] r;
      host_u.read(8'hfc, d, r);
      check({30'h0, r}, {30'h0, RESP_SLVERR});
      check(d, 32'h0);
      wr(OFF_STATUS, 32'h0, RESP_SLVERR);
      wr(OFF_CNT0, 32'h5, RESP_SLVERR);
      // Init and pick a window mode first, so the later arm sees it
      wr(OFF_CTRL, 32'h11, RESP_OKAY);
      for (int c = 0; c < 4; c++) begin
         rd(OFF_CNT0 + 8'(4 * c), d);
         check(d, 32'h0);
         wr(OFF_SEL0 + 8'(4 * c), 32'h0, RESP_OKAY);
      end
      rd(OFF_STATUS, d);
      check({28'h0, d[STAT_OVF_LSB +: 4]}, 32'h0);
      wr(OFF_CTRL, 32'h21, RESP_OKAY);
      rd(OFF_STATUS, d);
      check({30'h0, d[STAT_CFGERR_BIT], d[STAT_WIN_BIT]}, 32'h2);
      // A refused arm must not open a window on the start match
      pulse(2);
      rd(OFF_STATUS, d);
      check({31'h0, d[STAT_WIN_BIT]}, 32'h0);
   endtask : misc

   // Reset, then every event code across all three window modes
   initial begin
      srst_in = 1'b1;
      {prog_run_in, break_in, match1_in, match2_in} = 4'h0;
      events_in = '0;
      repeat (20) @(posedge clk_in);
      srst_in <= 1'b0;
      @(posedge clk_in);
      for (int r = 0; r < 10; r++) begin
         run_window(r % 3, 4 * r + 1);
      end
      misc();
      results();
   end
endmodule : cpu_performance_counter_unit_tb

bind pcu_top pcu_chk #(.NUM_CH(NUM_CH), .CNT_W(CNT_W)) chk_u (.*);
